// [cbca_engine_model.sv]
// Command engine and outside memory facing cbca_top.
// Assumes one command in flight at a time.
`timescale 1ns/100ps
module cbca_engine_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Pace chosen by the bench
	input wire logic slow,
	// Command side
	input wire logic cmd_start_q,
	input wire logic [1:0] cmd_instance_q,
	output logic cmd_captured,
	output logic [1:0] cmd_done,
	// Memory side
	input wire logic [7:0] page_q,
	input wire logic [7:0] bank_q,
	input wire logic [7:0] ptr_q,
	output logic [7:0] ext_rd_data
);
	logic [7:0] cnt;
	logic [1:0] inst;
	// Location mix, so a wrong page, bank or pointer reads back differently
	assign ext_rd_data = ptr_q ^ page_q ^ bank_q;
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt <= 8'h00;
			inst <= 2'h0;
			cmd_captured <= 1'b0;
			cmd_done <= 2'h0;
		end
		else
		begin
			cmd_captured <= cmd_start_q;
			cmd_done <= (cnt == 8'h01) ? inst : 2'h0;
			if (cmd_start_q)
			begin
				cnt <= slow ? 8'h28 : 8'h03;
				inst <= cmd_instance_q;
			end
			else if (cnt != 8'h00)
				cnt <= cnt - 8'h01;
		end
	end
endmodule // cbca_engine_model

// [cbca_pkg.sv]
// Constants for the command-block capability advertisement and its trigger logic.
// Assumes a byte-addressed management memory behind a two-wire serial front end.
package cbca_pkg;

	// ----------------------------------------------------------------
	// Pages and addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] PG_ADV = 8'h01;
	localparam logic [7:0] PG_CMD = 8'h9f;
	localparam logic [7:0] PG_EPL_FIRST = 8'ha0;
	localparam logic [7:0] ADDR_CAP = 8'ha3;
	localparam logic [7:0] ADDR_TRIG = 8'ha5;
	localparam logic [7:0] ADDR_BUSY = 8'ha6;
	localparam logic [7:0] ADDR_FLAG = 8'h08;
	localparam logic [7:0] ADDR_MASK = 8'h1f;
	localparam logic [7:0] ADDR_BANK = 8'h7e;
	localparam logic [7:0] ADDR_PAGE = 8'h7f;
	localparam logic [7:0] ADDR_COMMAND_IDENTIFIER_HI = 8'h80;
	localparam logic [7:0] ADDR_COMMAND_IDENTIFIER = 8'h81;
	localparam logic [7:0] ADDR_UPPER_FIRST = 8'h80;
	localparam logic [7:0] ADDR_UPPER_LAST = 8'hff;

	// ----------------------------------------------------------------
	// Field positions and encodings
	// ----------------------------------------------------------------
	localparam int CAP_INST_LSB = 6;
	localparam int CAP_BG_BIT = 5;
	localparam int CAP_AUTO_BIT = 4;
	localparam int TRIG_METHOD_BIT = 7;
	localparam int BUSY_SEL_BIT = 7;
	localparam int FLAG_LSB = 6;
	localparam logic [1:0] INST_NONE = 2'h0;
	localparam logic [1:0] INST_ONE = 2'h1;
	localparam logic [1:0] INST_TWO = 2'h2;
	localparam logic TRIG_ON_STOP_ANY = 1'b1;
	localparam logic BUSY_FMT_LONG = 1'b1;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] PAGE_RST = 8'h00;
	localparam logic [7:0] BANK_RST = 8'h00;
	localparam logic [7:0] PTR_RST = 8'h00;
	localparam logic [1:0] MASK_RST = 2'h0;
	localparam logic [1:0] FLAG_RST = 2'h0;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int LONG_BUSY_STEP_MS = 160;
	localparam int LONG_BUSY_MAX_MS = 4960;
	localparam int SHORT_BUSY_MAX_MS = 80;

	typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA} cbca_state_t;

endpackage

// [cbca_top.sv]
// Capability advertisement bytes, completion flags and command trigger detection.
// Assumes a same-clock serial front end that reports write starts, the address
// byte, data bytes, read requests and STOP as one-cycle pulses.
`timescale 1ns/100ps

module cbca_top #(
	parameter int unsigned INSTANCES = 1,
	parameter bit BACKGROUND = 1'b0,
	parameter bit AUTO_PAGE = 1'b0,
	parameter int unsigned EPL_PAGES = 1,
	parameter bit TRIGGER_METHOD = 1'b1,
	parameter bit BUSY_FORMAT = 1'b0,
	parameter int unsigned LONG_BUSY_CODE = 1,
	parameter int unsigned SHORT_BUSY_CODE = 80
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	input wire logic clk_en,
	// Serial front end events
	input wire logic xact_start,
	input wire logic addr_valid,
	input wire logic [7:0] addr_byte,
	input wire logic wr_valid,
	input wire logic [7:0] wr_data,
	input wire logic rd_req,
	input wire logic xact_stop,
	// Read answer
	output logic rd_valid_q,
	output logic [7:0] rd_data_q,
	// Management memory outside this block
	input wire logic [7:0] ext_rd_data,
	output logic mem_wr_q,
	output logic [7:0] mem_page_q,
	output logic [7:0] mem_bank_q,
	output logic [7:0] mem_addr_q,
	output logic [7:0] mem_data_q,
	output logic [7:0] page_q,
	output logic [7:0] bank_q,
	output logic [7:0] ptr_q,
	// Command engine
	output logic cmd_start_q,
	output logic [1:0] cmd_instance_q,
	output logic [7:0] cmd_bank_q,
	input wire logic cmd_captured,
	input wire logic [1:0] cmd_done,
	// Host status
	output logic hold_off_q,
	output logic [1:0] cmd_complete_flag_q,
	output logic attn_q
);

	// ----------------------------------------------------------------
	// Configuration checks and advertisement constants
	// ----------------------------------------------------------------
	if (INSTANCES > 2 || EPL_PAGES > 15 || LONG_BUSY_CODE > 31 || SHORT_BUSY_CODE > 127)
	begin : g_bad_cfg
		$error("cbca_top: configuration value out of range");
	end

	localparam logic [1:0] INST_CODE = 2'(INSTANCES);
	localparam logic [3:0] EPL_CODE = 4'(EPL_PAGES);
	localparam logic [7:0] EPL_LAST = 8'(cbca_pkg::PG_EPL_FIRST + 8'(EPL_PAGES) - 8'h01);

	// Fixed at build time; host writes never reach them
	localparam logic [7:0] ADV_CAP = {INST_CODE, BACKGROUND, AUTO_PAGE, EPL_CODE};
	localparam logic [7:0] ADV_TRIG = {TRIGGER_METHOD, 2'h0, 5'(LONG_BUSY_CODE)};
	localparam logic [7:0] ADV_BUSY = {BUSY_FORMAT, 7'(SHORT_BUSY_CODE)};

	// Completion flag bits that exist for the advertised instance count
	localparam logic [1:0] FLAG_LIVE = (INST_CODE == cbca_pkg::INST_TWO) ? 2'h3 :
		(INST_CODE == cbca_pkg::INST_ONE) ? 2'h1 : 2'h0;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic is_upper(input logic [7:0] a);
		is_upper = (a >= cbca_pkg::ADDR_UPPER_FIRST);
	endfunction

	function automatic logic is_adv_byte(input logic [7:0] pg, input logic [7:0] a);
		is_adv_byte = (pg == cbca_pkg::PG_ADV) &&
			(a == cbca_pkg::ADDR_CAP || a == cbca_pkg::ADDR_TRIG || a == cbca_pkg::ADDR_BUSY);
	endfunction

	function automatic logic in_epl(input logic [7:0] pg);
		in_epl = (pg >= cbca_pkg::PG_EPL_FIRST) && (pg <= EPL_LAST);
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	cbca_pkg::cbca_state_t st_q, st_d;
	logic [7:0] page_d, bank_d, ptr_d;
	logic [7:0] first_addr_q, first_addr_d;
	logic [7:0] first_page_q, first_page_d;
	logic [1:0] nbytes_q, nbytes_d;
	logic saw_command_identifier_q, saw_command_identifier_d;
	logic [1:0] mask_q, mask_d;
	logic [1:0] flag_d;
	logic [1:0] busy_q, busy_d;
	logic hold_d, attn_d;
	logic rd_valid_d;
	logic [7:0] rd_data_d;
	logic mem_wr_d;
	logic [7:0] mem_page_d, mem_bank_d, mem_addr_d, mem_data_d;
	logic cmd_start_d;
	logic [1:0] cmd_instance_d;
	logic [7:0] cmd_bank_d;
	logic trig;
	logic bank_ok;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		st_d = st_q;
		page_d = page_q;
		bank_d = bank_q;
		ptr_d = ptr_q;
		first_addr_d = first_addr_q;
		first_page_d = first_page_q;
		nbytes_d = nbytes_q;
		saw_command_identifier_d = saw_command_identifier_q;
		mask_d = mask_q;
		flag_d = cmd_complete_flag_q;
		busy_d = busy_q;
		hold_d = hold_off_q;
		rd_valid_d = 1'b0;
		rd_data_d = rd_data_q;
		mem_wr_d = 1'b0;
		mem_page_d = mem_page_q;
		mem_bank_d = mem_bank_q;
		mem_addr_d = mem_addr_q;
		mem_data_d = mem_data_q;
		cmd_start_d = 1'b0;
		cmd_instance_d = cmd_instance_q;
		cmd_bank_d = cmd_bank_q;
		trig = 1'b0;
		bank_ok = (bank_q < 8'(INSTANCES));

		// Reads: local bytes answered here, the rest by the outside memory
		if (rd_req && !hold_off_q)
		begin
			rd_valid_d = 1'b1;
			ptr_d = (ptr_q == cbca_pkg::ADDR_UPPER_LAST) ? cbca_pkg::ADDR_UPPER_FIRST :
				8'(ptr_q + 8'h01);
			if (is_adv_byte(page_q, ptr_q))
			begin
				case (ptr_q)
					cbca_pkg::ADDR_CAP: rd_data_d = ADV_CAP;
					cbca_pkg::ADDR_TRIG: rd_data_d = ADV_TRIG;
					default: rd_data_d = ADV_BUSY;
				endcase
			end
			else if (!is_upper(ptr_q))
			begin
				case (ptr_q)
					cbca_pkg::ADDR_FLAG: rd_data_d = {cmd_complete_flag_q, 6'h00};
					cbca_pkg::ADDR_MASK: rd_data_d = {mask_q, 6'h00};
					cbca_pkg::ADDR_BANK: rd_data_d = bank_q;
					cbca_pkg::ADDR_PAGE: rd_data_d = page_q;
					default: rd_data_d = ext_rd_data;
				endcase
				// Latched flags clear on read
				if (ptr_q == cbca_pkg::ADDR_FLAG)
					flag_d = 2'h0;
			end
			else
				rd_data_d = ext_rd_data;
		end

		// Write transaction tracking
		case (st_q)
			cbca_pkg::ST_IDLE:
			begin
				if (xact_start)
					st_d = cbca_pkg::ST_ADDR;
			end
			cbca_pkg::ST_ADDR:
			begin
				if (addr_valid)
				begin
					ptr_d = addr_byte;
					first_addr_d = addr_byte;
					first_page_d = page_q;
					nbytes_d = 2'h0;
					saw_command_identifier_d = 1'b0;
					st_d = cbca_pkg::ST_DATA;
				end
			end
			cbca_pkg::ST_DATA:
			begin
				// Writes are dropped while access is held off
				if (wr_valid && !hold_off_q)
				begin
					if (nbytes_q != 2'h3)
						nbytes_d = 2'(nbytes_q + 2'h1);
					if (page_q == cbca_pkg::PG_CMD && ptr_q == cbca_pkg::ADDR_COMMAND_IDENTIFIER)
						saw_command_identifier_d = 1'b1;
					if (!is_upper(ptr_q))
					begin
						case (ptr_q)
							cbca_pkg::ADDR_PAGE: page_d = wr_data;
							cbca_pkg::ADDR_BANK: bank_d = wr_data;
							cbca_pkg::ADDR_MASK: mask_d = wr_data[cbca_pkg::FLAG_LSB +: 2] & FLAG_LIVE;
							cbca_pkg::ADDR_FLAG: ;
							default: mem_wr_d = 1'b1;
						endcase
					end
					else if (!is_adv_byte(page_q, ptr_q))
						mem_wr_d = 1'b1;
					mem_page_d = page_q;
					mem_bank_d = bank_q;
					mem_addr_d = ptr_q;
					mem_data_d = wr_data;
					if (ptr_q == cbca_pkg::ADDR_UPPER_LAST)
					begin
						ptr_d = cbca_pkg::ADDR_UPPER_FIRST;
						if (AUTO_PAGE && in_epl(page_q))
							page_d = (page_q == EPL_LAST) ? cbca_pkg::PG_EPL_FIRST :
								8'(page_q + 8'h01);
					end
					else
						ptr_d = 8'(ptr_q + 8'h01);
				end
			end
			default: st_d = cbca_pkg::ST_IDLE;
		endcase

		// STOP closes the transaction and may start a command
		if (xact_stop)
		begin
			st_d = cbca_pkg::ST_IDLE;
			if (st_q == cbca_pkg::ST_DATA)
			begin
				if (TRIGGER_METHOD == cbca_pkg::TRIG_ON_STOP_ANY)
					trig = saw_command_identifier_q;
				else
					trig = (first_page_q == cbca_pkg::PG_CMD) &&
						((nbytes_q == 2'h1 && first_addr_q == cbca_pkg::ADDR_COMMAND_IDENTIFIER) ||
						(nbytes_q == 2'h2 && first_addr_q == cbca_pkg::ADDR_COMMAND_IDENTIFIER_HI));
			end
		end

		// Only advertised banks own a command instance
		if (trig && bank_ok && !busy_q[bank_q[0]])
		begin
			cmd_start_d = 1'b1;
			cmd_bank_d = bank_q;
			cmd_instance_d = 2'(bank_q + 8'h01);
			busy_d[bank_q[0]] = 1'b1;
			hold_d = 1'b1;
		end

		// Completion: set wins over a read-clear in the same cycle
		for (int i = 0; i < 2; i++)
		begin
			if (cmd_done[i] && FLAG_LIVE[i])
			begin
				busy_d[i] = 1'b0;
				flag_d[i] = 1'b1;
			end
		end

		// Background mode releases access on capture, otherwise on completion
		if (BACKGROUND)
		begin
			if (cmd_captured && !cmd_start_d)
				hold_d = 1'b0;
		end
		else if (busy_d == 2'h0)
			hold_d = 1'b0;

		attn_d = |(flag_d & ~mask_d);
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_q <= cbca_pkg::ST_IDLE;
			page_q <= cbca_pkg::PAGE_RST;
			bank_q <= cbca_pkg::BANK_RST;
			ptr_q <= cbca_pkg::PTR_RST;
			first_addr_q <= cbca_pkg::PTR_RST;
			first_page_q <= cbca_pkg::PAGE_RST;
			nbytes_q <= 2'h0;
			saw_command_identifier_q <= 1'b0;
			mask_q <= cbca_pkg::MASK_RST;
			cmd_complete_flag_q <= cbca_pkg::FLAG_RST;
			busy_q <= 2'h0;
			hold_off_q <= 1'b0;
			attn_q <= 1'b0;
			rd_valid_q <= 1'b0;
			rd_data_q <= 8'h00;
			mem_wr_q <= 1'b0;
			mem_page_q <= 8'h00;
			mem_bank_q <= 8'h00;
			mem_addr_q <= 8'h00;
			mem_data_q <= 8'h00;
			cmd_start_q <= 1'b0;
			cmd_instance_q <= cbca_pkg::INST_NONE;
			cmd_bank_q <= 8'h00;
		end
		else if (clk_en)
		begin
			st_q <= st_d;
			page_q <= page_d;
			bank_q <= bank_d;
			ptr_q <= ptr_d;
			first_addr_q <= first_addr_d;
			first_page_q <= first_page_d;
			nbytes_q <= nbytes_d;
			saw_command_identifier_q <= saw_command_identifier_d;
			mask_q <= mask_d;
			cmd_complete_flag_q <= flag_d;
			busy_q <= busy_d;
			hold_off_q <= hold_d;
			attn_q <= attn_d;
			rd_valid_q <= rd_valid_d;
			rd_data_q <= rd_data_d;
			mem_wr_q <= mem_wr_d;
			mem_page_q <= mem_page_d;
			mem_bank_q <= mem_bank_d;
			mem_addr_q <= mem_addr_d;
			mem_data_q <= mem_data_d;
			cmd_start_q <= cmd_start_d;
			cmd_instance_q <= cmd_instance_d;
			cmd_bank_q <= cmd_bank_d;
		end
	end

endmodule // cbca_top

// [cbca_top_chk.sv]
// Concurrent checks on the ports of cbca_top, attached by bind.
// Assumes the design runs with background execution off.
`timescale 1ns/100ps
module cbca_top_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	input wire logic clk_en,
	// Host events
	input wire logic xact_stop,
	input wire logic rd_req,
	// Outputs watched, with the engine completion input
	input wire logic rd_valid_q,
	input wire logic [7:0] ptr_q,
	input wire logic cmd_start_q,
	input wire logic [1:0] cmd_instance_q,
	input wire logic [7:0] cmd_bank_q,
	input wire logic [1:0] cmd_done,
	input wire logic hold_off_q,
	input wire logic [1:0] cmd_complete_flag_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_rd_ans; rd_req && clk_en && !hold_off_q |=> rd_valid_q; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
	property p_rd_refuse; rd_req && clk_en && hold_off_q |=> !rd_valid_q; endproperty
	a_rd_refuse: assert property (p_rd_refuse) else $error("read during hold off");
	property p_start_hold; cmd_start_q |-> hold_off_q; endproperty
	a_start_hold: assert property (p_start_hold) else $error("start without hold off");
	property p_start_cause; cmd_start_q |-> $past(xact_stop && clk_en); endproperty
	a_start_cause: assert property (p_start_cause) else $error("start without stop");
	property p_inst_bank; cmd_start_q |-> cmd_instance_q == cmd_bank_q[1:0] + 2'h1; endproperty
	a_inst_bank: assert property (p_inst_bank) else $error("instance not bank plus one");
	property p_done_flag0; cmd_done[0] && clk_en |=> cmd_complete_flag_q[0]; endproperty
	a_done_flag0: assert property (p_done_flag0) else $error("flag one not set");
	property p_done_flag1; cmd_done[1] && clk_en |=> cmd_complete_flag_q[1]; endproperty
	a_done_flag1: assert property (p_done_flag1) else $error("flag two not set");
	property p_hold_keep; hold_off_q && cmd_done == 2'h0 |=> hold_off_q; endproperty
	a_hold_keep: assert property (p_hold_keep) else $error("hold off dropped early");
	property p_ptr_wrap;
		rd_req && clk_en && !hold_off_q && ptr_q == 8'hff |=> ptr_q == 8'h80;
	endproperty
	a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap");
endmodule // cbca_top_chk

bind cbca_top cbca_top_chk u_chk (.clk(clk), .rstn(rstn), .clk_en(clk_en),
	.xact_stop(xact_stop), .rd_req(rd_req), .rd_valid_q(rd_valid_q), .ptr_q(ptr_q),
	.cmd_start_q(cmd_start_q), .cmd_instance_q(cmd_instance_q), .cmd_bank_q(cmd_bank_q),
	.cmd_done(cmd_done), .hold_off_q(hold_off_q), .cmd_complete_flag_q(cmd_complete_flag_q));

// [cbca_top_tb_top.sv]
// Self-checking bench for cbca_top with the command engine model.
// Assumes the one-cycle event pulses of the serial front end.
`timescale 1ns/100ps
module cbca_top_tb_top;
	localparam logic [7:0] CAP = {2'b10, 1'b0, 1'b1, 4'h2};
	localparam logic [7:0] TRIG = {1'b1, 2'b00, 5'h05};
	localparam logic [7:0] BUSY = {1'b1, 7'h50};
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic clk_en = 1'b1;
	logic xact_start = 1'b0;
	logic addr_valid = 1'b0;
	logic [7:0] addr_byte = 8'h00;
	logic wr_valid = 1'b0;
	logic [7:0] wr_data = 8'h00;
	logic rd_req = 1'b0;
	logic xact_stop = 1'b0;
	logic slow = 1'b0;
	logic rd_valid_q, cmd_start_q, cmd_captured, hold_off_q, attn_q;
	logic [7:0] rd_data_q, ext_rd_data, page_q, bank_q, ptr_q, cmd_bank_q;
	logic [1:0] cmd_instance_q, cmd_done, cmd_complete_flag_q;
	logic mem_wr_q;
	logic [7:0] mem_page_q, mem_bank_q, mem_addr_q, mem_data_q;
	logic [31:0] exp_mem[$];
	logic [7:0] wq[$];
	logic [7:0] qe[$];
	logic [7:0] exp_rd[$];
	logic [7:0] exp_inst[$];
	logic [31:0] seed = 32'h24c20ff9;
	int errors = 0;
	int checks = 0;
	always #2.5 clk = ~clk;
	cbca_top #(.INSTANCES(2), .AUTO_PAGE(1'b1), .EPL_PAGES(2), .BUSY_FORMAT(1'b1),
		.LONG_BUSY_CODE(5), .SHORT_BUSY_CODE(80)) dut (
		.clk(clk), .rstn(rstn), .clk_en(clk_en), .xact_start(xact_start),
		.addr_valid(addr_valid), .addr_byte(addr_byte), .wr_valid(wr_valid),
		.wr_data(wr_data), .rd_req(rd_req), .xact_stop(xact_stop),
		.rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q), .ext_rd_data(ext_rd_data),
		.mem_wr_q(mem_wr_q), .mem_page_q(mem_page_q), .mem_bank_q(mem_bank_q),
		.mem_addr_q(mem_addr_q), .mem_data_q(mem_data_q),
		.page_q(page_q), .bank_q(bank_q), .ptr_q(ptr_q), .cmd_start_q(cmd_start_q),
		.cmd_instance_q(cmd_instance_q), .cmd_bank_q(cmd_bank_q),
		.cmd_captured(cmd_captured), .cmd_done(cmd_done), .hold_off_q(hold_off_q),
		.cmd_complete_flag_q(cmd_complete_flag_q), .attn_q(attn_q));
	cbca_engine_model eng (.clk(clk), .rstn(rstn), .slow(slow), .cmd_start_q(cmd_start_q),
		.cmd_instance_q(cmd_instance_q), .cmd_captured(cmd_captured), .cmd_done(cmd_done),
		.page_q(page_q), .bank_q(bank_q), .ptr_q(ptr_q), .ext_rd_data(ext_rd_data));
	function automatic logic [31:0] xs32(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	task automatic tick;
		@(posedge clk);
		#1;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a);
		xact_start = 1'b1;
		tick;
		xact_start = 1'b0;
		addr_valid = 1'b1;
		addr_byte = a;
		tick;
		addr_valid = 1'b0;
		while (wq.size() > 0)
		begin
			wr_valid = 1'b1;
			wr_data = wq.pop_front();
			tick;
		end
		wr_valid = 1'b0;
		xact_stop = 1'b1;
		tick;
		xact_stop = 1'b0;
	endtask
	// Reads stay back to back; rd_req drops only once the burst is over
	task automatic rd_at(input logic [7:0] a);
		wr(a);
		while (qe.size() > 0)
		begin
			exp_rd.push_back(qe.pop_front());
			rd_req = 1'b1;
			tick;
		end
		rd_req = 1'b0;
	endtask
	task automatic idle;
		int i;
		for (i = 0; i < 100 && hold_off_q !== 1'b0; i++)
			tick;
		cmp("hold off", 8'h00, {7'h00, hold_off_q});
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// An empty queue gives an unknown expectation, so a stray answer fails
	always @(posedge clk)
	begin
		if (rd_valid_q === 1'b1)
			cmp("read data", exp_rd.size() > 0 ? exp_rd.pop_front() : 8'hxx, rd_data_q);
		if (cmd_start_q === 1'b1)
			cmp("instance", exp_inst.size() > 0 ? exp_inst.pop_front() : 8'hxx,
				{6'h00, cmd_instance_q});
		if (mem_wr_q === 1'b1)
			cmp("memory write", exp_mem.size() > 0 ? exp_mem.pop_front() : 32'hx,
				{mem_page_q, mem_bank_q, mem_addr_q, mem_data_q});
	end
	initial
	begin
		repeat (16) @(posedge clk);
		#1;
		rstn = 1'b1;
		tick;
		wq = {8'h01};
		wr(8'h7f);
		for (int k = 0; k < 2; k++)
		begin
			qe = {CAP, 8'ha5, TRIG, BUSY};
			rd_at(8'ha3);
			seed = xs32(seed);
			wq = {seed[7:0], seed[15:8], seed[23:16], seed[31:24]};
			exp_mem.push_back({8'h01, 8'h00, 8'ha4, seed[15:8]});
			wr(8'ha3);
		end
		wq = {8'h00, 8'h9f};
		wr(8'h7e);
		exp_inst.push_back(8'h01);
		wq = {8'h55, 8'h01, 8'h02};
		exp_mem = {exp_mem, 32'h9f008055, 32'h9f008101, 32'h9f008202};
		wr(8'h80);
		rd_req = 1'b1;
		tick;
		rd_req = 1'b0;
		idle;
		cmp("attention", 8'h01, {7'h00, attn_q});
		qe = {8'h40};
		rd_at(8'h08);
		qe = {8'h00};
		rd_at(8'h08);
		wq = {8'h40};
		wr(8'h1f);
		qe = {8'h40};
		rd_at(8'h1f);
		wq = {8'h01, 8'h9f};
		wr(8'h7e);
		exp_inst.push_back(8'h02);
		slow = 1'b1;
		wq = {8'h07};
		exp_mem.push_back(32'h9f018107);
		wr(8'h81);
		idle;
		cmp("attention", 8'h01, {7'h00, attn_q});
		qe = {8'h80};
		rd_at(8'h08);
		wq = {8'h00, 8'ha0};
		wr(8'h7e);
		wq = {8'h11, 8'h22, 8'h33};
		exp_mem = {exp_mem, 32'ha000fe11, 32'ha000ff22, 32'ha1008033};
		wr(8'hfe);
		cmp("page", 8'ha1, page_q);
		cmp("pointer", 8'h81, ptr_q);
		wq = {8'h44, 8'h55};
		exp_mem = {exp_mem, 32'ha100ff44, 32'ha0008055};
		wr(8'hff);
		cmp("page", 8'ha0, page_q);
		qe = {8'h5f, 8'h20};
		rd_at(8'hff);
		repeat (4) tick;
		// Clock enable low: a standing read must neither answer nor move the pointer
		clk_en = 1'b0;
		rd_req = 1'b1;
		repeat (3) tick;
		rd_req = 1'b0;
		clk_en = 1'b1;
		tick;
		cmp("pointer", 8'h81, ptr_q);
		cmp("pending", 8'h00, 8'(exp_rd.size() + exp_inst.size() + exp_mem.size()));
		give_verdict;
	end
	initial
	begin
		repeat (5000) @(posedge clk);
		errors++;
		give_verdict;
	end
endmodule // cbca_top_tb_top
